// file: core/tm2_pkg.sv
`default_nettype none

package tm2_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_UNIT_MODE = 8'hc9;
  localparam logic [7:0] ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI = 8'hcd;
  // Index 0 is the reload/compare unit, 1..3 the plain compare/capture units
  localparam logic [3:0][7:0] ADDR_UNIT_LO = {8'hc6, 8'hc4, 8'hc2, 8'hca};
  localparam logic [3:0][7:0] ADDR_UNIT_HI = {8'hc7, 8'hc5, 8'hc3, 8'hcb};

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] UNIT_MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] UNIT_RESET = 16'h0000;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Prescaler divide ratios, in machine ticks
  localparam logic [4:0] DIV_FAST = 5'h02;
  localparam logic [4:0] DIV_SLOW = 5'h0c;
  localparam logic [4:0] DIV_SLOWER = 5'h18;

  // Count limits
  localparam logic [7:0] LO_TOP = 8'hff;
  localparam logic [15:0] CNT_TOP = 16'hffff;

  // Fixed interrupt vector of this timer
  localparam logic [15:0] TIMER_VECTOR = 16'h002b;

  // Edge capture latency per unit, in clock cycles
  localparam int CAP_LAT_UNIT0 = 1;
  localparam int CAP_LAT_OTHER = 2;

  // Pin slots in the synchroniser vector
  localparam int PIN_COUNT = 0;
  localparam int PIN_RELOAD = 1;
  localparam int PIN_CAP0 = 2;
  localparam int NUM_PINS = 5;

  typedef enum logic [1:0] {
    IN_STOP = 2'b00,
    IN_TIMER = 2'b01,
    IN_EVENT = 2'b10,
    IN_GATED = 2'b11
  } tm2_input_type;

  typedef enum logic [1:0] {
    UM_OFF = 2'b00,
    UM_EDGE = 2'b01,
    UM_COMPARE = 2'b10,
    UM_WRITE = 2'b11
  } tm2_unit_mode_type;

  // Layout of the timer control register, bit 7 first
  typedef struct packed {
    logic prescaler_select;
    logic prescaler_mode;
    logic count_size;
    logic reload_mode_hi;
    logic reload_mode_lo;
    logic compare_mode_select;
    logic input_select_hi;
    logic input_select_lo;
  } tm2_ctrl_type;

endpackage

`default_nettype wire

// file: core/tm2_timer.sv
`default_nettype none

module tm2_timer #(
  parameter int GDIV_SEL_W = 3
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [GDIV_SEL_W-1:0] global_clock_divider,
  input wire logic count_pin,
  input wire logic reload_pin,
  input wire logic [2:0] capture_pin,
  input wire logic reload_pin_int_enable,
  input wire logic timer_int_enable,
  input wire logic overflow_flag_clr,
  input wire logic reload_pin_flag_clr,
  output logic overflow_flag,
  output logic reload_pin_flag,
  output logic timer_irq,
  output logic [15:0] timer_int_vector,
  output logic compare_mode,
  output logic [3:0] compare_match
);

  localparam int GDIV_CNT_W = 1 << GDIV_SEL_W;

  generate
    if (GDIV_SEL_W < 1 || GDIV_SEL_W > 3) begin : g_bad_width
      $error("GDIV_SEL_W must be 1 to 3");
    end
  endgenerate

  tm2_pkg::tm2_ctrl_type ctrl_q;
  logic [7:0] unit_mode_q;
  logic [15:0] cnt_q;
  logic [3:0][15:0] unit_val;
  localparam int NUM_PINS_L = tm2_pkg::NUM_PINS;
  logic [NUM_PINS_L-1:0] pin_raw;
  logic [NUM_PINS_L-1:0] sync1_q, sync2_q, sync3_q, filt_q, mc_samp_q;
  logic [2:0] cap_prev_q;
  logic [GDIV_CNT_W-1:0] gdiv_q;
  logic [4:0] psc_q;
  logic evt_pend_q;
  logic overflow_flag_q, reload_pin_flag_q, timer_irq_q;
  logic [7:0] rdata_q;
  logic [15:0] vector_q;
  logic [3:0] match_q;

  logic base_tick, int_tick, inc_en, at_top, ovf_evt;
  logic count_fall, reload_fall, pin_reload, cnt_wr;
  logic [GDIV_CNT_W-1:0] gdiv_mask;
  logic [4:0] div_ratio;
  logic [2:0] cap_rise;
  tm2_pkg::tm2_input_type in_sel;
  logic [1:0] reload_sel;

  assign pin_raw = {capture_pin, reload_pin, count_pin};
  assign in_sel = tm2_pkg::tm2_input_type'({ctrl_q.input_select_hi, ctrl_q.input_select_lo});
  assign reload_sel = {ctrl_q.reload_mode_hi, ctrl_q.reload_mode_lo};
  assign cnt_wr = sfr_wr && (sfr_addr == tm2_pkg::ADDR_CNT_LO || sfr_addr == tm2_pkg::ADDR_CNT_HI);

  // Three-stage synchroniser; a level counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (filt_q & (sync2_q ^ sync3_q));
    end
  end

  // Global divider makes the machine tick, ahead of the prescaler
  assign gdiv_mask = GDIV_CNT_W'((1 << global_clock_divider) - 1);
  assign base_tick = (gdiv_q & gdiv_mask) == gdiv_mask;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gdiv_q <= '0;
    end else begin
      gdiv_q <= gdiv_q + GDIV_CNT_W'(1);
    end
  end

  // Prescaler: mode bit wins over select bit
  always_comb begin
    if (ctrl_q.prescaler_mode) begin
      div_ratio = tm2_pkg::DIV_FAST;
    end else if (ctrl_q.prescaler_select) begin
      div_ratio = tm2_pkg::DIV_SLOWER;
    end else begin
      div_ratio = tm2_pkg::DIV_SLOW;
    end
  end

  assign int_tick = base_tick && (psc_q >= div_ratio - 5'h01);

  // Wraps early if the ratio shrinks mid-count, so no long stall
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      psc_q <= '0;
    end else if (int_tick) begin
      psc_q <= '0;
    end else if (base_tick) begin
      psc_q <= psc_q + 5'h01;
    end
  end

  // Pins sampled once per machine tick for falling edges
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mc_samp_q <= '0;
    end else if (base_tick) begin
      mc_samp_q <= filt_q;
    end
  end

  assign count_fall = base_tick && mc_samp_q[tm2_pkg::PIN_COUNT] && !filt_q[tm2_pkg::PIN_COUNT];
  assign reload_fall = base_tick && mc_samp_q[tm2_pkg::PIN_RELOAD] && !filt_q[tm2_pkg::PIN_RELOAD];

  // Event count lands in the cycle after the fall is seen
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      evt_pend_q <= 1'b0;
    end else begin
      evt_pend_q <= count_fall && in_sel == tm2_pkg::IN_EVENT;
    end
  end

  // Increment source by input select
  always_comb begin
    unique case (in_sel)
      tm2_pkg::IN_STOP: inc_en = 1'b0;
      tm2_pkg::IN_TIMER: inc_en = int_tick;
      tm2_pkg::IN_EVENT: inc_en = evt_pend_q;
      tm2_pkg::IN_GATED: inc_en = int_tick && filt_q[tm2_pkg::PIN_COUNT];
    endcase
  end

  assign at_top = ctrl_q.count_size ? (cnt_q[7:0] == tm2_pkg::LO_TOP) : (cnt_q == tm2_pkg::CNT_TOP);
  // Reload pin in its mode takes any size setting
  assign pin_reload = reload_fall && reload_sel == 2'b11;
  assign ovf_evt = inc_en && at_top && !pin_reload && !cnt_wr;

  // Counter: software write, then pin reload, then overflow, then count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q <= tm2_pkg::CNT_RESET;
    end else if (sfr_wr && sfr_addr == tm2_pkg::ADDR_CNT_LO) begin
      cnt_q[7:0] <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == tm2_pkg::ADDR_CNT_HI) begin
      cnt_q[15:8] <= sfr_wdata;
    end else if (pin_reload) begin
      cnt_q <= unit_val[0];
    end else if (ovf_evt && reload_sel == 2'b10) begin
      cnt_q <= unit_val[0];
    end else if (inc_en && ctrl_q.count_size) begin
      cnt_q[7:0] <= cnt_q[7:0] + 8'h01;
    end else if (inc_en) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Flags: a set in the clear cycle wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_q <= 1'b1;
    end else if (overflow_flag_clr) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reload_pin_flag_q <= 1'b0;
    end else if (reload_fall && reload_pin_int_enable) begin
      reload_pin_flag_q <= 1'b1;
    end else if (reload_pin_flag_clr) begin
      reload_pin_flag_q <= 1'b0;
    end
  end

  // Single timer request, with its fixed vector
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timer_irq_q <= 1'b0;
      vector_q <= tm2_pkg::TIMER_VECTOR;
    end else begin
      timer_irq_q <= timer_int_enable && (overflow_flag_q || reload_pin_flag_q);
      vector_q <= tm2_pkg::TIMER_VECTOR;
    end
  end

  // Control and unit mode registers
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= tm2_pkg::CTRL_RESET;
      unit_mode_q <= tm2_pkg::UNIT_MODE_RESET;
    end else if (sfr_wr && sfr_addr == tm2_pkg::ADDR_CTRL) begin
      ctrl_q <= sfr_wdata;
    end else if (sfr_wr && sfr_addr == tm2_pkg::ADDR_UNIT_MODE) begin
      unit_mode_q <= sfr_wdata;
    end
  end

  // Rising edges at the capture pins, per clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cap_prev_q <= '0;
    end else begin
      cap_prev_q <= filt_q[tm2_pkg::PIN_CAP0 +: 3];
    end
  end

  assign cap_rise = filt_q[tm2_pkg::PIN_CAP0 +: 3] & ~cap_prev_q;

  // One compare/capture unit per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_unit
      tm2_pkg::tm2_unit_mode_type mode;
      logic [15:0] unit_q;
      logic [1:0] cap_pipe_q;
      logic cap_now, wr_lo, wr_hi, match;

      assign mode = tm2_pkg::tm2_unit_mode_type'(unit_mode_q[2*gi +: 2]);
      assign wr_lo = sfr_wr && sfr_addr == tm2_pkg::ADDR_UNIT_LO[gi];
      assign wr_hi = sfr_wr && sfr_addr == tm2_pkg::ADDR_UNIT_HI[gi];

      // Unit 3 has no pin, so its edge setting never captures
      if (gi < 3) begin : g_pin
        always_ff @(posedge ref_clk) begin
          if (srst) begin
            cap_pipe_q <= '0;
          end else begin
            cap_pipe_q <= {cap_pipe_q[0], cap_rise[gi] && mode == tm2_pkg::UM_EDGE};
          end
        end
        assign cap_now = (gi == 0) ? cap_pipe_q[tm2_pkg::CAP_LAT_UNIT0 - 1]
                                   : cap_pipe_q[tm2_pkg::CAP_LAT_OTHER - 1];
      end else begin : g_nopin
        assign cap_pipe_q = '0;
        assign cap_now = 1'b0;
      end

      // Capture takes all 16 bits at once and leaves the counter alone
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          unit_q <= tm2_pkg::UNIT_RESET;
        end else if (wr_lo && mode == tm2_pkg::UM_WRITE) begin
          unit_q <= cnt_q;
        end else if (cap_now) begin
          unit_q <= cnt_q;
        end else if (wr_lo) begin
          unit_q[7:0] <= sfr_wdata;
        end else if (wr_hi) begin
          unit_q[15:8] <= sfr_wdata;
        end
      end

      assign match = mode == tm2_pkg::UM_COMPARE &&
                     (ctrl_q.count_size ? cnt_q[7:0] == unit_q[7:0] : cnt_q == unit_q);

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          match_q[gi] <= 1'b0;
        end else begin
          match_q[gi] <= match;
        end
      end

      assign unit_val[gi] = unit_q;
    end
  endgenerate

  // Register read, answered one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= tm2_pkg::RDATA_UNMAPPED;
    end else if (sfr_rd) begin
      rdata_q <= tm2_pkg::RDATA_UNMAPPED;
      if (sfr_addr == tm2_pkg::ADDR_CTRL) rdata_q <= ctrl_q;
      if (sfr_addr == tm2_pkg::ADDR_UNIT_MODE) rdata_q <= unit_mode_q;
      if (sfr_addr == tm2_pkg::ADDR_CNT_LO) rdata_q <= cnt_q[7:0];
      if (sfr_addr == tm2_pkg::ADDR_CNT_HI) rdata_q <= cnt_q[15:8];
      for (int i = 0; i < 4; i++) begin
        if (sfr_addr == tm2_pkg::ADDR_UNIT_LO[i]) rdata_q <= unit_val[i][7:0];
        if (sfr_addr == tm2_pkg::ADDR_UNIT_HI[i]) rdata_q <= unit_val[i][15:8];
      end
    end
  end

  assign sfr_rdata = rdata_q;
  assign overflow_flag = overflow_flag_q;
  assign reload_pin_flag = reload_pin_flag_q;
  assign timer_irq = timer_irq_q;
  assign timer_int_vector = vector_q;
  assign compare_mode = ctrl_q.compare_mode_select;
  assign compare_match = match_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  ovf_reload_a: assert property (
    ovf_evt && reload_sel == 2'b10 |=> cnt_q == $past(unit_val[0]) && overflow_flag_q)
    else $error("overflow reload missed");
  stop_hold_a: assert property (
    in_sel == tm2_pkg::IN_STOP && !cnt_wr && !pin_reload |=> $stable(cnt_q))
    else $error("timer moved while stopped");
  pin_reload_a: assert property (
    pin_reload && !cnt_wr && !overflow_flag_clr |=>
      cnt_q == $past(unit_val[0]) && overflow_flag_q == $past(overflow_flag_q))
    else $error("pin reload wrong");
  event_inc_a: assert property (
    count_fall && in_sel == tm2_pkg::IN_EVENT ##1 in_sel == tm2_pkg::IN_EVENT |-> inc_en)
    else $error("event count not applied next cycle");
  gated_hold_a: assert property (
    in_sel == tm2_pkg::IN_GATED && !filt_q[tm2_pkg::PIN_COUNT] |-> !inc_en)
    else $error("gated timer counted while pin low");
  size8_hi_a: assert property (
    inc_en && ctrl_q.count_size && !cnt_wr && !pin_reload && !at_top |=> $stable(cnt_q[15:8]))
    else $error("high byte moved in 8-bit mode");
  cap_unit1_a: assert property (
    cap_rise[1] && g_unit[1].mode == tm2_pkg::UM_EDGE && !sfr_wr ##1 !sfr_wr ##1 !sfr_wr
      |-> unit_val[1] == $past(unit_val[1]) ##1 unit_val[1] == $past(cnt_q))
    else $error("unit 1 capture not two cycles");
  flag_irq_a: assert property (
    timer_int_enable && (overflow_flag_q || reload_pin_flag_q) |=> timer_irq_q)
    else $error("timer interrupt not raised");
  rp_flag_a: assert property (
    reload_fall && reload_pin_int_enable |=> reload_pin_flag_q)
    else $error("reload pin flag not set");

  ovf_seen_c: cover property (ovf_evt && reload_sel == 2'b10);
  pin_reload_c: cover property (pin_reload ##1 timer_irq_q);
  cap0_c: cover property (g_unit[0].cap_now);
  match_c: cover property (match_q[2]);

endmodule

`default_nettype wire

// file: bench/tm2_pin_model.sv
`default_nettype none

// Far side of the timer pins; every level is held for several ticks
// so the sampler still sees it when the machine tick is slowed down
module tm2_pin_model (
  input wire logic ref_clk,
  output logic count_pin,
  output logic reload_pin,
  output logic [2:0] capture_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle levels: fall-sensitive pins rest high, capture pins low
  initial begin
    count_pin = 1'b1;
    reload_pin = 1'b1;
    capture_pin = 3'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Static level for gated counting
  task automatic set_count(input logic lvl);
    count_pin = lvl;
    hold(1);
  endtask

  // Falling edges for the event counter
  task automatic pulse_count(input int n, input int len);
    repeat (n) begin
      count_pin = 1'b0;
      hold(len);
      count_pin = 1'b1;
      hold(len);
    end
  endtask

  task automatic fall_reload(input int len);
    reload_pin = 1'b0;
    hold(len);
    reload_pin = 1'b1;
    hold(len);
  endtask

  task automatic rise_capture(input int idx, input int len);
    capture_pin[idx] = 1'b1;
    hold(len);
    capture_pin[idx] = 1'b0;
    hold(len);
  endtask
endmodule

`default_nettype wire

// file: bench/test_tm2_timer.sv
`default_nettype none

module test_tm2_timer;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, srst, sfr_wr, sfr_rd, rd_chk, rd_q, chk_q;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, last_rd;
  logic [2:0] gdiv, capture_pin;
  logic count_pin, reload_pin, rp_en, int_en, of_clr, rp_clr;
  logic overflow_flag, reload_pin_flag, timer_irq, compare_mode;
  logic [15:0] timer_int_vector, cval, rval;
  logic [3:0] compare_match;
  logic [7:0] exp_q[$];
  logic [7:0] rt_ctl[8] = '{8'h41, 8'h01, 8'h81, 8'h41, 8'h01, 8'h43, 8'h43, 8'h40};
  logic [2:0] rt_g[8] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
  logic rt_pin[8] = '{1, 1, 1, 1, 1, 1, 0, 1};
  int rt_div[8] = '{2, 12, 24, 4, 24, 2, 0, 0};
  logic [7:0] pr_ctl[3] = '{8'h18, 8'h38, 8'h10};
  logic pr_en[3] = '{0, 1, 1};
  logic pr_ld[3] = '{1, 1, 0};
  int n_fail, check_count, n, e;

  tm2_timer dut_u (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .global_clock_divider(gdiv),
    .count_pin(count_pin), .reload_pin(reload_pin), .capture_pin(capture_pin),
    .reload_pin_int_enable(rp_en), .timer_int_enable(int_en), .overflow_flag_clr(of_clr),
    .reload_pin_flag_clr(rp_clr), .overflow_flag(overflow_flag), .reload_pin_flag(reload_pin_flag),
    .timer_irq(timer_irq), .timer_int_vector(timer_int_vector), .compare_mode(compare_mode),
    .compare_match(compare_match));

  tm2_pin_model part_u (.ref_clk(ref_clk), .count_pin(count_pin), .reload_pin(reload_pin),
    .capture_pin(capture_pin));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    check_count++;
    if (seen !== expd) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read answers arrive one cycle after the strobe; oldest note is compared
  always @(posedge ref_clk) begin
    if (rd_q) begin
      last_rd = sfr_rdata;
      if (chk_q) check({8'h00, sfr_rdata}, {8'h00, exp_q.pop_front()});
    end
    rd_q <= sfr_rd;
    chk_q <= rd_chk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    // Let an edge pass so back-to-back writes never re-raise the strobe at once
    sfr_wr = 1'b0;
    tick(1);
  endtask

  task automatic wr16(input logic [7:0] alo, input logic [7:0] ahi, input logic [15:0] d);
    wr(alo, d[7:0]);
    wr(ahi, d[15:8]);
  endtask

  task automatic rd(input logic [7:0] a, input logic use_exp, input logic [7:0] expd);
    sfr_addr = a;
    sfr_rd = 1'b1;
    rd_chk = use_exp;
    if (use_exp) exp_q.push_back(expd);
    tick(1);
    sfr_rd = 1'b0;
    rd_chk = 1'b0;
    tick(1);
  endtask

  task automatic rd16(input logic [7:0] alo, input logic [7:0] ahi, input logic [15:0] expd);
    rd(alo, 1'b1, expd[7:0]);
    rd(ahi, 1'b1, expd[15:8]);
  endtask

  // Watchdog, well beyond the few thousand cycles the sequence needs
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    {sfr_wr, sfr_rd, rd_chk, rd_q, chk_q, rp_en, int_en, of_clr, rp_clr} = '0;
    {sfr_addr, sfr_wdata, gdiv} = '0;
    srst = 1'b1;
    void'($urandom(31));
    tick(20);
    srst = 0;
    // Reset values, then an unmapped place that must stay empty
    rd(tm2_pkg::ADDR_CTRL, 1'b1, 8'h00);
    rd(tm2_pkg::ADDR_UNIT_MODE, 1'b1, 8'h00);
    rd16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h0000);
    for (int u = 0; u < 4; u++) rd16(tm2_pkg::ADDR_UNIT_LO[u], tm2_pkg::ADDR_UNIT_HI[u], 16'h0000);
    wr(8'hc1, 8'hff);
    rd(8'hc1, 1'b1, 8'h00);
    check(timer_int_vector, 16'h002b);
    check({12'h000, compare_match}, 16'h0000);
    // Rates over 481 cycles; phase of the prescaler allows a small slack
    for (int i = 0; i < 8; i++) begin
      gdiv = rt_g[i];
      part_u.set_count(rt_pin[i]);
      tick(4);
      wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h0000);
      wr(tm2_pkg::ADDR_CTRL, rt_ctl[i]);
      tick(479);
      wr(tm2_pkg::ADDR_CTRL, 8'h00);
      rd(tm2_pkg::ADDR_CNT_HI, 1'b1, 8'h00);
      rd(tm2_pkg::ADDR_CNT_LO, 1'b0, 8'h00);
      e = (rt_div[i] == 0) ? 0 : 481 / rt_div[i];
      n = (rt_div[i] == 0) ? 0 : 2;
      check({15'h0000, int'(last_rd) >= e - n && int'(last_rd) <= e + n}, 16'h0001);
    end
    gdiv = 3'h0;
    // Event counting of five falls
    wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h0000);
    wr(tm2_pkg::ADDR_CTRL, 8'h02);
    part_u.pulse_count(5, 6);
    tick(8);
    rd16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h0005);
    // 8-bit size: low byte rolls, high byte is left alone
    wr(tm2_pkg::ADDR_CTRL, 8'h00);
    wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h12fe);
    wr(tm2_pkg::ADDR_CTRL, 8'h61);
    tick(12);
    wr(tm2_pkg::ADDR_CTRL, 8'h00);
    rd(tm2_pkg::ADDR_CNT_HI, 1'b1, 8'h12);
    of_clr = 1'b1;
    tick(1);
    of_clr = 1'b0;
    // Overflow without and with reload from unit 0
    int_en = 1'b1;
    wr16(tm2_pkg::ADDR_UNIT_LO[0], tm2_pkg::ADDR_UNIT_HI[0], 16'hfff0);
    for (int m = 0; m < 2; m++) begin
      wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'hfffc);
      wr(tm2_pkg::ADDR_CTRL, (m == 1) ? 8'h51 : 8'h41);
      n = 0;
      while (overflow_flag !== 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
      tick(1);
      check({15'h0000, timer_irq}, 16'h0001);
      wr(tm2_pkg::ADDR_CTRL, 8'h00);
      rd(tm2_pkg::ADDR_CNT_HI, 1'b1, (m == 1) ? 8'hff : 8'h00);
      int_en = 1'b0;
      tick(2);
      check({14'h0000, overflow_flag, timer_irq}, 16'h0002);
      of_clr = 1'b1;
      tick(1);
      of_clr = 1'b0;
      int_en = 1'b1;
      tick(2);
      check({14'h0000, overflow_flag, timer_irq}, 16'h0000);
    end
    // Pin reload, with and without the flag enable, and ignored in mode 10
    rval = 16'($urandom());
    wr16(tm2_pkg::ADDR_UNIT_LO[0], tm2_pkg::ADDR_UNIT_HI[0], rval);
    wr16(tm2_pkg::ADDR_UNIT_LO[1], tm2_pkg::ADDR_UNIT_HI[1], ~rval);
    for (int i = 0; i < 3; i++) begin
      rp_en = pr_en[i];
      wr(tm2_pkg::ADDR_CTRL, pr_ctl[i]);
      wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, 16'h1234);
      part_u.fall_reload(6);
      tick(4);
      rd16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, pr_ld[i] ? rval : 16'h1234);
      check({13'h0000, overflow_flag, reload_pin_flag, timer_irq}, {14'h0000, rp_en, rp_en});
      rp_clr = 1'b1;
      tick(1);
      rp_clr = 1'b0;
    end
    // Edge capture on units 0..2, unit 3 has no pin and keeps its value
    cval = 16'($urandom());
    wr(tm2_pkg::ADDR_CTRL, 8'h00);
    wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, cval);
    wr16(tm2_pkg::ADDR_UNIT_LO[3], tm2_pkg::ADDR_UNIT_HI[3], 16'h5a5a);
    wr(tm2_pkg::ADDR_UNIT_MODE, 8'h55);
    for (int u = 0; u < 3; u++) part_u.rise_capture(u, 6);
    tick(4);
    for (int u = 0; u < 4; u++) rd16(tm2_pkg::ADDR_UNIT_LO[u], tm2_pkg::ADDR_UNIT_HI[u], (u == 3) ? 16'h5a5a : cval);
    rd16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, cval);
    // Capture on low-byte write in every unit
    cval = ~cval;
    wr16(tm2_pkg::ADDR_CNT_LO, tm2_pkg::ADDR_CNT_HI, cval);
    wr(tm2_pkg::ADDR_UNIT_MODE, 8'hff);
    for (int u = 0; u < 4; u++) begin
      wr(tm2_pkg::ADDR_UNIT_LO[u], 8'h00);
      rd16(tm2_pkg::ADDR_UNIT_LO[u], tm2_pkg::ADDR_UNIT_HI[u], cval);
    end
    // Compare against full pair, then against the low byte only
    wr(tm2_pkg::ADDR_UNIT_MODE, 8'haa);
    wr16(tm2_pkg::ADDR_UNIT_LO[0], tm2_pkg::ADDR_UNIT_HI[0], cval + 16'h0001);
    wr16(tm2_pkg::ADDR_UNIT_LO[1], tm2_pkg::ADDR_UNIT_HI[1], cval);
    wr16(tm2_pkg::ADDR_UNIT_LO[2], tm2_pkg::ADDR_UNIT_HI[2], {~cval[15:8], cval[7:0]});
    wr16(tm2_pkg::ADDR_UNIT_LO[3], tm2_pkg::ADDR_UNIT_HI[3], cval - 16'h0001);
    for (int s = 0; s < 2; s++) begin
      wr(tm2_pkg::ADDR_CTRL, (s == 1) ? 8'h24 : 8'h00);
      tick(3);
      check({12'h000, compare_match}, (s == 1) ? 16'h0006 : 16'h0002);
      check({15'h0000, compare_mode}, 16'(s));
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
